//--- inc/ppa_pkg.sv
/*
  Constants and types shared by the parallel-port address pin mux.
  Assumes one clock domain and a synchronous, active-high reset.
*/
package ppa_pkg;

  // width of the shared address pins and of the host port buses
  localparam int unsigned PPA_ADDR_W = 16;
  localparam int unsigned PPA_DATA_W = 16;

  // reset values, and the full drive enable used in memory mode
  localparam logic [PPA_ADDR_W-1:0] PPA_ADDR_RST   = 16'h0000;
  localparam logic [PPA_ADDR_W-1:0] PPA_OE_OFF     = 16'h0000;
  localparam logic [PPA_ADDR_W-1:0] PPA_OE_ALL     = 16'hFFFF;
  localparam logic                  PPA_HOLD_RST   = 1'b1;
  localparam logic                  PPA_STRAP_RST  = 1'b0;

  // latched pin role; gray codes along reset -> host and reset -> memory
  typedef enum logic [1:0] {
    PPA_MODE_RESET = 2'b00,
    PPA_MODE_HOST  = 2'b01,
    PPA_MODE_EMEM  = 2'b10
  } ppa_mode_e;

endpackage : ppa_pkg

//--- inc/ppa_hold_if.sv
/*
  Carrier between the pin mux and its bus holder.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface ppa_hold_if;
  import ppa_pkg::*;

  logic                  sw_en;     // software holder enable
  logic [PPA_ADDR_W-1:0] drive_val; // level the mux drives
  logic                  drive_oe;  // mux drives the pins
  logic [PPA_ADDR_W-1:0] pin_val;   // synchronised pin level
  logic                  hold_en;   // holder active
  logic [PPA_ADDR_W-1:0] hold_val;  // level the holder keeps

  modport mux    (output sw_en, drive_val, drive_oe, pin_val,
                  input  hold_en, hold_val);
  modport holder (input  sw_en, drive_val, drive_oe, pin_val,
                  output hold_en, hold_val);
endinterface : ppa_hold_if

//--- design/ppa_bus_holder.sv
/*
  Bus holder for the sixteen address pins: remembers the last driven level.
  Assumes the mux feeds it through ppa_hold_if on the same clock.
*/
`timescale 1ns/1ps
module ppa_bus_holder
  import ppa_pkg::*;
(
  input wire logic  mclk_i,
  input wire logic  rst_i,
  ppa_hold_if.holder hb
);

  ////////////////////////////////////////////////////////////////////////////
  // enable: on at reset, then follows the software bit
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      hb.hold_en <= PPA_HOLD_RST; // [RULE_04]
    end else begin
      hb.hold_en <= hb.sw_en;     // [RULE_04]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // last level: own drive when driving, else what the pins settled at
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      hb.hold_val <= PPA_ADDR_RST;
    end else if (hb.drive_oe) begin
      hb.hold_val <= hb.drive_val; // [RULE_03]
    end else begin
      hb.hold_val <= hb.pin_val;   // [RULE_03]
    end
  end

endmodule : ppa_bus_holder

//--- design/ppa_pin_mux.sv
/*
  Role selection for the sixteen parallel-port address pins: host port
  address inputs or external memory address outputs, chosen by a strap
  caught during reset and fixed at its release.
  Assumes pins and the strap are asynchronous; the memory interface address
  and the holder enable come from logic on mclk_i. The pad cell resolves
  pad_addr_o / pad_addr_oe_o and the weak holder drive into the wire.
*/
`timescale 1ns/1ps

// Overview of operation
// RULE_01: strap low host address, high memory address
// RULE_02: role fixed at reset release until reset
// RULE_03: holders keep last driven pin level
// RULE_04: holders on at reset, software bit toggles
// RULE_05: host mode pins are inputs after reset
// RULE_06: strap low selects non-multiplexed host port
// RULE_07: host uses separate 16-bit address, data
// RULE_08: one 16-bit data word per host cycle
// RULE_09: memory address pins high impedance in reset
// RULE_10: memory address driven zero after reset
// RULE_11: no cross-mode driving or passing of values
module ppa_pin_mux
  import ppa_pkg::*;
(
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  input  wire logic                  boot_select_strap_i,
  input  wire logic [PPA_ADDR_W-1:0] pad_addr_i,
  output logic      [PPA_ADDR_W-1:0] pad_addr_o,
  output logic      [PPA_ADDR_W-1:0] pad_addr_oe_o,
  input  wire logic [PPA_ADDR_W-1:0] ext_mem_address_i,
  input  wire logic                  ext_mem_access_i,
  input  wire logic                  holder_sw_en_i,
  output logic                       holder_en_o,
  output logic      [PPA_ADDR_W-1:0] holder_level_o,
  output logic      [PPA_ADDR_W-1:0] host_port_address_o,
  output logic                       host_mode_o,
  output logic                       host_nonmux_o,
  output logic                       ext_mem_mode_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic                  strap_meta;
  logic                  strap_sync;
  logic                  strap_cap;
  logic [PPA_ADDR_W-1:0] pad_meta;
  logic [PPA_ADDR_W-1:0] pad_sync;
  ppa_mode_e             mode;
  ppa_mode_e             next_mode;
  logic                  next_emem;
  logic                  next_host;
  logic [PPA_ADDR_W-1:0] next_pad_addr;

  ppa_hold_if hold_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for the strap and the address pins
  always_ff @(posedge mclk_i) begin
    strap_meta <= boot_select_strap_i;
    strap_sync <= strap_meta;
    pad_meta   <= pad_addr_i;
    pad_sync   <= pad_meta;
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap follows the pin while reset is held; frozen afterwards
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      strap_cap <= strap_sync; // [RULE_02]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode: the role is taken on the first edge with reset low,
  // then frozen until the next reset
  function automatic ppa_mode_e role_next(input logic      in_rst,
                                          input ppa_mode_e cur,
                                          input logic      strap_hi);
    ppa_mode_e nxt;
    nxt = PPA_MODE_RESET;
    if (!in_rst) begin
      case (cur)
        PPA_MODE_RESET: begin
          if (strap_hi) begin
            nxt = PPA_MODE_EMEM; // [RULE_01]
          end else begin
            nxt = PPA_MODE_HOST; // [RULE_01] [RULE_06]
          end
        end
        PPA_MODE_HOST: nxt = PPA_MODE_HOST;  // [RULE_02]
        PPA_MODE_EMEM: nxt = PPA_MODE_EMEM;  // [RULE_02]
        default:       nxt = PPA_MODE_RESET; // illegal code: relatch from the strap
      endcase
    end
    return nxt;
  endfunction : role_next

  assign next_mode = role_next(rst_i, mode, strap_cap); // [RULE_01] [RULE_02]
  assign next_emem = (next_mode == PPA_MODE_EMEM);
  assign next_host = (next_mode == PPA_MODE_HOST);

  // memory address: zero at entry, then updated only by an access
  assign next_pad_addr = !next_emem                          ? PPA_ADDR_RST      : // [RULE_11]
                         (mode != PPA_MODE_EMEM)             ? PPA_ADDR_RST      : // [RULE_10]
                         ext_mem_access_i                    ? ext_mem_address_i :
                                                               pad_addr_o;

  ////////////////////////////////////////////////////////////////////////////
  // mode register and mode flags
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode           <= PPA_MODE_RESET;
      host_mode_o    <= 1'b0;
      host_nonmux_o  <= 1'b0;
      ext_mem_mode_o <= 1'b0;
    end else begin
      mode           <= next_mode;
      host_mode_o    <= next_host;
      host_nonmux_o  <= next_host; // [RULE_06] [RULE_07] [RULE_08]
      ext_mem_mode_o <= next_emem;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive: released in reset and in host mode, full drive in memory mode
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pad_addr_o    <= PPA_ADDR_RST;
      pad_addr_oe_o <= PPA_OE_OFF;  // [RULE_09]
    end else begin
      pad_addr_o    <= next_pad_addr;
      pad_addr_oe_o <= next_emem ? PPA_OE_ALL : PPA_OE_OFF; // [RULE_05] [RULE_10] [RULE_11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host port address: pins pass through only while host mode is latched
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      host_port_address_o <= PPA_ADDR_RST;
    end else if (mode == PPA_MODE_HOST) begin
      host_port_address_o <= pad_sync;     // [RULE_01] [RULE_07]
    end else begin
      host_port_address_o <= PPA_ADDR_RST; // [RULE_11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus holder
  assign hold_bus.sw_en     = holder_sw_en_i;
  assign hold_bus.drive_val = pad_addr_o;
  assign hold_bus.drive_oe  = pad_addr_oe_o[0];
  assign hold_bus.pin_val   = pad_sync;
  assign holder_en_o        = hold_bus.hold_en;
  assign holder_level_o     = hold_bus.hold_val;

  ppa_bus_holder u_holder (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .hb     (hold_bus.holder)
  );

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_release;
    rst_i ##1 !rst_i;
  endsequence

  sequence s_emem_entry;
    s_release ##0 strap_cap;
  endsequence

  sequence s_host_entry;
    s_release ##0 !strap_cap;
  endsequence

  a_reset_hiz_pins: assert property (disable iff (1'b0) // [RULE_09]
    rst_i |=> (pad_addr_oe_o == PPA_OE_OFF))
    else $error("address pins driven during reset");

  a_strap_sets_mode: assert property (disable iff (1'b0) // [RULE_01]
    s_release |=> (mode == (strap_cap ? PPA_MODE_EMEM : PPA_MODE_HOST)))
    else $error("latched mode does not match strap");

  a_mode_stays_fixed: assert property ( // [RULE_02]
    (mode != PPA_MODE_RESET) |=> (mode == $past(mode)))
    else $error("pin role changed outside reset");

  a_emem_zero_start: assert property (disable iff (1'b0) // [RULE_10]
    s_emem_entry |=> (pad_addr_o == PPA_ADDR_RST) && (pad_addr_oe_o == PPA_OE_ALL))
    else $error("memory address not driven zero after reset");

  a_host_zero_start: assert property (disable iff (1'b0) // [RULE_05]
    s_host_entry |=> (pad_addr_oe_o == PPA_OE_OFF) && (host_port_address_o == PPA_ADDR_RST)
                     && host_nonmux_o)
    else $error("host mode entry drives pins or lacks non-multiplexed flag");

  a_emem_access_drive: assert property ( // [RULE_10]
    (mode == PPA_MODE_EMEM) && ext_mem_access_i |=> (pad_addr_o == $past(ext_mem_address_i))
                                                    && (pad_addr_oe_o == PPA_OE_ALL))
    else $error("memory access address not on pins");

  a_emem_addr_holds: assert property ( // [RULE_10]
    (mode == PPA_MODE_EMEM) && !ext_mem_access_i |=> (pad_addr_o == $past(pad_addr_o)))
    else $error("memory address changed without an access");

  a_emem_pins_out: assert property ( // [RULE_10]
    (mode == PPA_MODE_EMEM) |-> (pad_addr_oe_o == PPA_OE_ALL) && ext_mem_mode_o)
    else $error("memory mode pins not driven");

  a_host_pins_input: assert property ( // [RULE_05]
    (mode == PPA_MODE_HOST) |-> (pad_addr_oe_o == PPA_OE_OFF) && host_nonmux_o)
    else $error("host mode pins driven or not non-multiplexed");

  a_host_drives_none: assert property ( // [RULE_11]
    (mode == PPA_MODE_HOST) |-> (pad_addr_o == PPA_ADDR_RST) && !ext_mem_mode_o)
    else $error("memory address value present in host mode");

  a_host_addr_route: assert property ( // [RULE_01]
    (mode == PPA_MODE_HOST) ##1 (mode == PPA_MODE_HOST)
      |-> (host_port_address_o == $past(pad_sync)))
    else $error("pins not routed to host port address");

  a_no_cross_mode: assert property ( // [RULE_11]
    (mode == PPA_MODE_EMEM) |=> (host_port_address_o == PPA_ADDR_RST) && !host_mode_o)
    else $error("pins passed to host port in memory mode");

  a_holder_at_reset: assert property (disable iff (1'b0) // [RULE_04]
    rst_i |=> holder_en_o)
    else $error("bus holder not enabled at reset");

  a_holder_follows_sw: assert property ( // [RULE_04]
    !rst_i ##1 !rst_i |-> (holder_en_o == $past(holder_sw_en_i)))
    else $error("bus holder ignores software enable");

  a_holder_keeps_level: assert property ( // [RULE_03]
    pad_addr_oe_o[0] |=> (holder_level_o == $past(pad_addr_o)))
    else $error("holder lost the driven level");

endmodule : ppa_pin_mux

//--- bench/ppa_pin_model.sv
/*
  Far side of the address pins: a host that presents an address, and the
  wire that resolves device drive, host drive and the weak holder drive.
  Assumes the holder drives weakly and that all output enables are equal.
*/
`timescale 1ns/1ps
module ppa_pin_model
  import ppa_pkg::*;
(
  input  wire logic                  host_drive_i,
  input  wire logic [PPA_ADDR_W-1:0] host_addr_i,
  input  wire logic [PPA_ADDR_W-1:0] pad_val_i,
  input  wire logic [PPA_ADDR_W-1:0] pad_oe_i,
  input  wire logic                  hold_en_i,
  input  wire logic [PPA_ADDR_W-1:0] hold_val_i,
  output logic      [PPA_ADDR_W-1:0] pin_o
);
  logic [PPA_ADDR_W-1:0] last_level = PPA_ADDR_RST;

  //////////////////////////////////////////////////////////////////////////
  // wire level: device, then host address, then holder, else a floating pin
  assign pin_o = pad_oe_i[0] ? pad_val_i :
                 host_drive_i ? host_addr_i : // host presents 16-bit address
                 hold_en_i ? hold_val_i : ~last_level; // undriven pin keeps nothing

  // remember the last real level so a floating pin shows its inverse
  always @(pin_o) begin
    if (pad_oe_i[0] | host_drive_i | hold_en_i) last_level = pin_o;
  end
endmodule : ppa_pin_model

//--- bench/parallel_port_address_pin_mux_tb.sv
/*
  Self-checking bench for the address pin mux: host mode, memory mode,
  holder behaviour and the enable switch.
  Assumes a 100 MHz clock and the pin model on the far side.
*/
`timescale 1ns/1ps
module parallel_port_address_pin_mux_tb;
  import ppa_pkg::*;
  logic                  mclk_i, rst_i, strap, acc, sw_en, host_drv;
  logic                  hold_en, host_mode, nonmux, emem_mode;
  logic [PPA_ADDR_W-1:0] mem_addr, host_addr, pin, pad_val, pad_oe, hold_val, host_pa;
  int                    num_errors = 0;
  int                    total_checks = 0;

  //////////////////////////////////////////////////////////////////////////
  // design and far side
  ppa_pin_mux u_ppa_pin_mux (.mclk_i(mclk_i), .rst_i(rst_i),
    .boot_select_strap_i(strap), .pad_addr_i(pin), .pad_addr_o(pad_val),
    .pad_addr_oe_o(pad_oe), .ext_mem_address_i(mem_addr), .ext_mem_access_i(acc),
    .holder_sw_en_i(sw_en), .holder_en_o(hold_en), .holder_level_o(hold_val),
    .host_port_address_o(host_pa), .host_mode_o(host_mode),
    .host_nonmux_o(nonmux), .ext_mem_mode_o(emem_mode));
  ppa_pin_model u_ppa_pin_model (.host_drive_i(host_drv), .host_addr_i(host_addr),
    .pad_val_i(pad_val), .pad_oe_i(pad_oe), .hold_en_i(hold_en),
    .hold_val_i(hold_val), .pin_o(pin));

  //////////////////////////////////////////////////////////////////////////
  // clock, helpers and compares
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : step

  task automatic chk16(input logic [PPA_ADDR_W-1:0] got, input logic [PPA_ADDR_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  // reset for three edges, check the reset state, then release
  task automatic do_reset(input logic s);
    rst_i = 1'b1;
    strap = s;
    step(3);
    chk16(pad_oe, PPA_OE_OFF);
    chk1(hold_en, PPA_HOLD_RST);
    rst_i = 1'b0;
    step(1);
  endtask : do_reset

  //////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_host;
    do_reset(1'b0);
    chk1(host_mode, 1'b1);
    chk1(nonmux, 1'b1);
    chk1(emem_mode, 1'b0);
    chk16(pad_oe, PPA_OE_OFF);
    host_addr = 16'hA5C3;
    host_drv = 1'b1;
    strap = 1'b1;
    acc = 1'b1;
    mem_addr = 16'h1234;
    step(3);
    chk16(host_pa, 16'hA5C3);
    chk16(pad_oe, PPA_OE_OFF);
    chk16(pad_val, PPA_ADDR_RST);
    chk1(host_mode, 1'b1);
    host_drv = 1'b0;
    acc = 1'b0;
    step(4);
    chk16(pin, 16'hA5C3);
    chk16(hold_val, 16'hA5C3);
    $display("test_host done");
  endtask : test_host

  task automatic test_mem;
    acc = 1'b1;
    mem_addr = 16'hBEEF;
    do_reset(1'b1);
    chk1(emem_mode, 1'b1);
    chk1(host_mode, 1'b0);
    chk16(pad_oe, PPA_OE_ALL);
    chk16(pad_val, PPA_ADDR_RST);
    strap = 1'b0;
    mem_addr = 16'h1234;
    step(1);
    chk16(pad_val, 16'h1234);
    mem_addr = 16'hFFFF;
    step(1);
    chk16(pad_val, 16'hFFFF);
    acc = 1'b0;
    mem_addr = 16'h0F0F;
    step(3);
    chk16(pad_val, 16'hFFFF);
    chk16(hold_val, 16'hFFFF);
    chk16(host_pa, PPA_ADDR_RST);
    chk1(emem_mode, 1'b1);
    $display("test_mem done");
  endtask : test_mem

  task automatic test_holder;
    sw_en = 1'b0;
    step(1);
    chk1(hold_en, 1'b0);
    sw_en = 1'b1;
    step(1);
    chk1(hold_en, 1'b1);
    $display("test_holder done");
  endtask : test_holder

  //////////////////////////////////////////////////////////////////////////
  // verdict, watchdog and main sequence
  task automatic final_report;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #5000; // about twenty times the length of a clean run
    num_errors++;
    final_report();
  end

  initial begin
    acc = 1'b0;
    sw_en = 1'b1;
    host_drv = 1'b0;
    mem_addr = PPA_ADDR_RST;
    host_addr = PPA_ADDR_RST;
    test_host();
    test_mem();
    test_holder();
    final_report();
  end
endmodule : parallel_port_address_pin_mux_tb
